// *** poc_board_model.sv ***
// Board model: external package pins and the circuitry behind them
module poc_board_model
  import poc_pkg::*;
(
  // Pins from the device
  input wire logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_out,
  input wire logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_oe_n,
  // Board sources on released pins
  input wire logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] ext_val,
  // Wire levels back to the device
  output logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_in
);
  // Device drive wins where enabled, else the board source sets the level
  always_comb
  begin
    pin_in = (pin_out & ~pin_oe_n) | (ext_val & pin_oe_n);
  end
endmodule : poc_board_model

// *** poc_crossbar.sv ***
// Port pin orientation crossbar with APB register file
// Overview of operation
// - Flash serial pins stay detached from ports unless program-mode pin is high.
// - Low-frequency select 000 uses port-0 pins 0 and 1 as crystal terminals.
// - Low-frequency select 011 takes a low-amplitude clock from port-0 pin 1.
// - Low-frequency select 100 uses a full-swing digital clock source.
// - Reset makes every pin an input feeding the processor input path.
// - Orientation bit 0 means output, bit 1 means input.
// - Port-0 orientation register is 8 bits, bit n for pin n.
// - Port-1 orientation register is 8 bits, bit n for pin n.
// - One to four ports exist depending on build; absent bits drive nothing.
// - Port-0 pin 7 exists only in medium and large builds.
// - Port 1 exists only in medium and large builds.
// - Port-1 pin 7 exists only in the large build.
// - Orientation only sets direction; options come from per-port option registers.
// - Port-3 orientation bit 7 is reserved and controls no pin.
// - Port-2 and port-3 orientation sit at 0x95, 0x96, reset 0xFF.
//
// The implementer's own choice: the APB interface to the registers.
module poc_crossbar
  import poc_pkg::*;
#(
  parameter int PKG_BUILD = PKG_LARGE
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Package pins
  input wire logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_in,
  output logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_out,
  output logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_oe_n,
  // Processor general-purpose data paths
  input wire logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] gpio_out,
  output logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] gpio_in,
  // Per-port functional options
  output logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_option,
  // Flash programming serial port
  input wire logic program_mode_pin,
  input wire logic flash_miso,
  output logic flash_sck,
  output logic flash_mosi,
  output logic flash_csn_n,
  // Low-frequency clock source
  output logic lf_xtal_en,
  output logic lf_lowamp_sel,
  output logic lf_lowamp_clk,
  output logic lf_digital_sel
);

  localparam int NUM_PORTS = poc_num_ports(PKG_BUILD);

  // Register file
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_orientation_regs_r;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_orientation_regs_nxt;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_option_regs_r;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_option_regs_nxt;
  logic [2:0] lowfreq_clock_select_r;
  logic [2:0] lowfreq_clock_select_nxt;
  logic [APB_DW-1:0] prdata_r;
  logic [APB_DW-1:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic pslverr_nxt;

  logic [IDX_W-1:0] idx;
  logic aligned;
  logic setup;
  logic wr;
  logic hit;
  logic [REG_W-1:0] rd_byte;

  assign idx = paddr[APB_AW-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & pready_r;

  always_comb
  begin
    port_orientation_regs_nxt = port_orientation_regs_r;
    port_option_regs_nxt = port_option_regs_r;
    lowfreq_clock_select_nxt = lowfreq_clock_select_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    hit = 1'b0;
    rd_byte = MASK_NONE;
    // Address decode
    for (int p = 0; p < NUM_PORT_SLOTS; p++)
    begin
      if (aligned && idx == IDX_PORT0_ORIENT + IDX_W'(p))
      begin
        hit = 1'b1;
        rd_byte = port_orientation_regs_r[p];
        if (wr)
        begin
          port_orientation_regs_nxt[p] = pwdata[REG_W-1:0];
        end
      end
      if (aligned && idx == IDX_PORT0_OPTION + IDX_W'(p))
      begin
        hit = 1'b1;
        rd_byte = port_option_regs_r[p];
        if (wr)
        begin
          port_option_regs_nxt[p] = pwdata[REG_W-1:0];
        end
      end
    end
    if (aligned && idx == IDX_LF_SELECT)
    begin
      hit = 1'b1;
      rd_byte = {5'h00, lowfreq_clock_select_r};
      if (wr)
      begin
        lowfreq_clock_select_nxt = pwdata[2:0];
      end
    end
    // Read data and error are prepared in the setup cycle
    if (setup)
    begin
      prdata_nxt = {24'h000000, rd_byte};
      pslverr_nxt = ~hit;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      port_orientation_regs_r <= {NUM_PORT_SLOTS{ORIENT_RESET}};
      port_option_regs_r <= {NUM_PORT_SLOTS{OPTION_RESET}};
      lowfreq_clock_select_r <= LF_SEL_RESET;
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      port_orientation_regs_r <= port_orientation_regs_nxt;
      port_option_regs_r <= port_option_regs_nxt;
      lowfreq_clock_select_r <= lowfreq_clock_select_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= 1'b1;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Special-function steering of the pin cells
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] detach;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] force_en;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] force_val;

  always_comb
  begin
    detach = '0;
    force_en = '0;
    force_val = '0;
    if (lowfreq_clock_select_r == LF_SEL_XTAL)
    begin
      detach[LF_PORT][LF_XTAL_PIN_A] = 1'b1;
      detach[LF_PORT][LF_CLK_PIN] = 1'b1;
    end
    if (lowfreq_clock_select_r == LF_SEL_LOWAMP)
    begin
      detach[LF_PORT][LF_CLK_PIN] = 1'b1;
    end
    if (program_mode_pin)
    begin
      force_en[FL_MISO_PORT][FL_MISO_PIN] = 1'b1;
      force_val[FL_MISO_PORT][FL_MISO_PIN] = flash_miso;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORT_SLOTS; gp++)
    begin : g_port
      poc_pin_cell #(
        .PRESENT((gp < NUM_PORTS) ? poc_pin_mask(PKG_BUILD, gp) : MASK_NONE)
      ) u_cell (
        .clk(clk),
        .sys_rst(sys_rst),
        .dir(port_orientation_regs_r[gp]),
        .detach(detach[gp]),
        .force_en(force_en[gp]),
        .force_val(force_val[gp]),
        .gpio_out(gpio_out[gp]),
        .gpio_in(gpio_in[gp]),
        .pin_in(pin_in[gp]),
        .pin_out(pin_out[gp]),
        .pin_oe_n(pin_oe_n[gp])
      );
    end
  endgenerate

  // Flash port and low-frequency clock outputs
  localparam logic [REG_W-1:0] P2_MASK = (NUM_PORTS > FL_CSN_PORT) ? poc_pin_mask(PKG_BUILD, FL_CSN_PORT) : MASK_NONE;
  logic flash_sck_r;
  logic flash_mosi_r;
  logic flash_csn_n_r;
  logic lf_xtal_en_r;
  logic lf_lowamp_sel_r;
  logic lf_lowamp_clk_r;
  logic lf_digital_sel_r;
  logic flash_sck_nxt;
  logic flash_mosi_nxt;
  logic flash_csn_n_nxt;

  always_comb
  begin
    flash_sck_nxt = program_mode_pin & pin_in[FL_SCK_PORT][FL_SCK_PIN];
    flash_mosi_nxt = program_mode_pin & pin_in[FL_MOSI_PORT][FL_MOSI_PIN];
    flash_csn_n_nxt = ~program_mode_pin | pin_in[FL_CSN_PORT][FL_CSN_PIN] | ~P2_MASK[FL_CSN_PIN];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flash_sck_r <= 1'b0;
      flash_mosi_r <= 1'b0;
      flash_csn_n_r <= 1'b1;
      lf_xtal_en_r <= 1'b0;
      lf_lowamp_sel_r <= 1'b0;
      lf_lowamp_clk_r <= 1'b0;
      lf_digital_sel_r <= 1'b0;
    end
    else
    begin
      flash_sck_r <= flash_sck_nxt;
      flash_mosi_r <= flash_mosi_nxt;
      flash_csn_n_r <= flash_csn_n_nxt;
      lf_xtal_en_r <= (lowfreq_clock_select_r == LF_SEL_XTAL);
      lf_lowamp_sel_r <= (lowfreq_clock_select_r == LF_SEL_LOWAMP);
      lf_lowamp_clk_r <= (lowfreq_clock_select_r == LF_SEL_LOWAMP) & pin_in[LF_PORT][LF_CLK_PIN];
      lf_digital_sel_r <= (lowfreq_clock_select_r == LF_SEL_DIGITAL);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign port_option = port_option_regs_r;
  assign flash_sck = flash_sck_r;
  assign flash_mosi = flash_mosi_r;
  assign flash_csn_n = flash_csn_n_r;
  assign lf_xtal_en = lf_xtal_en_r;
  assign lf_lowamp_sel = lf_lowamp_sel_r;
  assign lf_lowamp_clk = lf_lowamp_clk_r;
  assign lf_digital_sel = lf_digital_sel_r;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  localparam logic [APB_AW-1:0] ADDR_P0 = {IDX_PORT0_ORIENT, 2'h0};
  localparam logic [APB_AW-1:0] ADDR_P3 = {IDX_PORT3_ORIENT, 2'h0};

  a_reset_all_input: assert property (disable iff (1'b0) sys_rst |=> (pin_oe_n == '1) && (pin_out == '0) && (gpio_in == '0))
    else $error("pins not all inputs after reset");
  a_write_then_pin: assert property (wr && paddr == ADDR_P0 |=> port_orientation_regs_r[0] == $past(pwdata[7:0])
    ##1 pin_oe_n[0][4] == $past(port_orientation_regs_r[0][4]))
    else $error("orientation write did not reach pin enable");
  a_dir_to_oe: assert property (##1 pin_oe_n[0][5] == $past(port_orientation_regs_r[0][5]))
    else $error("pin enable does not follow orientation bit");
  a_flash_idle: assert property (!program_mode_pin |=> !flash_sck && !flash_mosi && flash_csn_n)
    else $error("flash port active outside program mode");
  a_xtal_detach: assert property (lowfreq_clock_select_r == LF_SEL_XTAL |=> pin_oe_n[0][1:0] == 2'h3 && lf_xtal_en)
    else $error("crystal pins still driven");
  a_lowamp_clk: assert property (lowfreq_clock_select_r == LF_SEL_LOWAMP |=> lf_lowamp_clk == $past(pin_in[0][1]))
    else $error("low-amplitude clock not taken from pin");
  a_digital_sel: assert property (##1 lf_digital_sel == ($past(lowfreq_clock_select_r) == LF_SEL_DIGITAL))
    else $error("digital clock select wrong");
  a_reserved_pin: assert property (pin_oe_n[3][7] && pin_out[3][7] == 1'b0)
    else $error("reserved port-3 pin driven");
  a_read_back: assert property (setup && !pwrite && paddr == ADDR_P3 |=> prdata[7:0] == $past(port_orientation_regs_r[3])
    && !pslverr)
    else $error("orientation read data wrong");

  c_write_p0: cover property (wr && paddr == ADDR_P0 ##2 pin_oe_n[0] != MASK_ALL);
  c_program_mode_pin_mode: cover property (program_mode_pin [*3]);
  c_xtal_mode: cover property (lf_xtal_en);
  c_unmapped: cover property (psel && penable && pslverr);

endmodule : poc_crossbar

// *** poc_pin_cell.sv ***
// One 8-pin port: registered direction, output value and input sampling
module poc_pin_cell
  import poc_pkg::*;
#(
  parameter logic [REG_W-1:0] PRESENT = MASK_ALL
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control from the register file and the flash programming port
  input wire logic [REG_W-1:0] dir,
  input wire logic [REG_W-1:0] detach,
  input wire logic [REG_W-1:0] force_en,
  input wire logic [REG_W-1:0] force_val,
  // Processor data paths
  input wire logic [REG_W-1:0] gpio_out,
  output logic [REG_W-1:0] gpio_in,
  // Pins
  input wire logic [REG_W-1:0] pin_in,
  output logic [REG_W-1:0] pin_out,
  output logic [REG_W-1:0] pin_oe_n
);

  logic [REG_W-1:0] oe_n_r;
  logic [REG_W-1:0] oe_n_nxt;
  logic [REG_W-1:0] out_r;
  logic [REG_W-1:0] out_nxt;
  logic [REG_W-1:0] in_r;
  logic [REG_W-1:0] in_nxt;

  always_comb
  begin
    // Absent and detached pins never drive; any other forced pin drives whatever its direction bit
    oe_n_nxt = ~PRESENT | detach | (dir & ~force_en);
    out_nxt = PRESENT & ((force_en & force_val) | (~force_en & ~detach & gpio_out));
    in_nxt = PRESENT & pin_in;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      oe_n_r <= MASK_ALL;
      out_r <= MASK_NONE;
      in_r <= MASK_NONE;
    end
    else
    begin
      oe_n_r <= oe_n_nxt;
      out_r <= out_nxt;
      in_r <= in_nxt;
    end
  end

  assign pin_oe_n = oe_n_r;
  assign pin_out = out_r;
  assign gpio_in = in_r;

endmodule : poc_pin_cell

// *** poc_pkg.sv ***
// Constants, register map and build masks for the port pin orientation crossbar
package poc_pkg;

  // Package builds
  localparam int PKG_SMALL = 0;
  localparam int PKG_MEDIUM = 1;
  localparam int PKG_LARGE = 2;

  localparam int NUM_PORT_SLOTS = 4;
  localparam int PINS_PER_PORT = 8;

  // APB geometry
  localparam int APB_AW = 12;
  localparam int APB_DW = 32;
  localparam int IDX_W = 10;
  localparam int REG_W = 8;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PORT0_ORIENT = 10'h093;
  localparam logic [IDX_W-1:0] IDX_PORT1_ORIENT = 10'h094;
  localparam logic [IDX_W-1:0] IDX_PORT2_ORIENT = 10'h095;
  localparam logic [IDX_W-1:0] IDX_PORT3_ORIENT = 10'h096;
  localparam logic [IDX_W-1:0] IDX_PORT0_OPTION = 10'h0A0;
  localparam logic [IDX_W-1:0] IDX_LF_SELECT = 10'h0A8;

  // Reset values
  localparam logic [REG_W-1:0] ORIENT_RESET = 8'hFF;
  localparam logic [REG_W-1:0] OPTION_RESET = 8'h00;
  localparam logic [2:0] LF_SEL_RESET = 3'h1;

  // Low-frequency clock select codes
  localparam logic [2:0] LF_SEL_XTAL = 3'h0;
  localparam logic [2:0] LF_SEL_LOWAMP = 3'h3;
  localparam logic [2:0] LF_SEL_DIGITAL = 3'h4;

  // Special pin positions
  localparam int LF_PORT = 0;
  localparam int LF_XTAL_PIN_A = 0;
  localparam int LF_CLK_PIN = 1;
  localparam int FL_SCK_PORT = 1;
  localparam int FL_SCK_PIN = 2;
  localparam int FL_MOSI_PORT = 1;
  localparam int FL_MOSI_PIN = 5;
  localparam int FL_MISO_PORT = 1;
  localparam int FL_MISO_PIN = 6;
  localparam int FL_CSN_PORT = 2;
  localparam int FL_CSN_PIN = 0;

  // Pin presence masks per build
  localparam logic [REG_W-1:0] MASK_NONE = 8'h00;
  localparam logic [REG_W-1:0] MASK_LOW7 = 8'h7F;
  localparam logic [REG_W-1:0] MASK_ALL = 8'hFF;

  function automatic logic [REG_W-1:0] poc_pin_mask(input int pkg, input int port);
    logic [REG_W-1:0] m;
    m = MASK_NONE;
    case (port)
      0: m = (pkg == PKG_SMALL) ? MASK_LOW7 : MASK_ALL;
      1: m = (pkg == PKG_SMALL) ? MASK_NONE : ((pkg == PKG_MEDIUM) ? MASK_LOW7 : MASK_ALL);
      2: m = (pkg == PKG_LARGE) ? MASK_ALL : MASK_NONE;
      3: m = (pkg == PKG_LARGE) ? MASK_LOW7 : MASK_NONE;
      default: m = MASK_NONE;
    endcase
    return m;
  endfunction : poc_pin_mask

  function automatic int poc_num_ports(input int pkg);
    return (pkg == PKG_SMALL) ? 1 : ((pkg == PKG_MEDIUM) ? 2 : 4);
  endfunction : poc_num_ports

endpackage : poc_pkg

// *** test_port_pin_orientation_crossbar.sv ***
// Self-checking testbench for the port pin orientation crossbar
module test_port_pin_orientation_crossbar
  import poc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, er;
  logic program_mode_pin, flash_miso, flash_sck, flash_mosi, flash_csn_n;
  logic lf_xtal_en, lf_lowamp_sel, lf_lowamp_clk, lf_digital_sel;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rd;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] pin_in, pin_out, pin_oe_n, gpio_out, gpio_in;
  logic [NUM_PORT_SLOTS-1:0][REG_W-1:0] port_option, ext_val, oe_s, oe_m;
  int error_cnt, checked;

  poc_crossbar #(.PKG_BUILD(PKG_LARGE)) u_dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe_n, .gpio_out, .gpio_in,
    .port_option, .program_mode_pin, .flash_miso, .flash_sck, .flash_mosi, .flash_csn_n,
    .lf_xtal_en, .lf_lowamp_sel, .lf_lowamp_clk, .lf_digital_sel);
  // Smaller builds share the bus so that pin presence can be compared
  poc_crossbar #(.PKG_BUILD(PKG_SMALL)) u_dut_small (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .pin_in, .pin_out(), .pin_oe_n(oe_s),
    .gpio_out, .gpio_in(), .port_option(), .program_mode_pin, .flash_miso, .flash_sck(),
    .flash_mosi(), .flash_csn_n(), .lf_xtal_en(), .lf_lowamp_sel(), .lf_lowamp_clk(),
    .lf_digital_sel());
  poc_crossbar #(.PKG_BUILD(PKG_MEDIUM)) u_dut_med (.clk, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata(), .pready(), .pslverr(), .pin_in, .pin_out(), .pin_oe_n(oe_m),
    .gpio_out, .gpio_in(), .port_option(), .program_mode_pin, .flash_miso, .flash_sck(),
    .flash_mosi(), .flash_csn_n(), .lf_xtal_en(), .lf_lowamp_sel(), .lf_lowamp_clk(),
    .lf_digital_sel());
  poc_board_model u_board (.pin_out, .pin_oe_n, .ext_val, .pin_in);

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // One APB transfer; ends at the edge where pready was seen; a stuck slave only counts a mismatch
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16)
    begin
      error_cnt++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_reset();
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b0, {IDX_PORT0_ORIENT + 10'(p), 2'b00}, 32'h0);
      chk("orient_rst", rd, 32'h0000_00FF);
    end
    chk("oe_n_rst", pin_oe_n, 32'hFFFF_FFFF);
    chk("gpio_in_rst", gpio_in, ext_val & 32'h7FFF_FFFF);
  endtask : t_reset

  task automatic t_dir();
    logic [31:0] v;
    v = 32'h00C3_0F5A;
    for (int p = 0; p < 4; p++)
      apb(1'b1, {IDX_PORT0_ORIENT + 10'(p), 2'b00}, {24'hABCDE0, v[8*p+:8]});
    tick(1);
    chk("oe_n_old", pin_oe_n[3], 8'hFF);
    tick(1);
    chk("oe_n_new", pin_oe_n, v | 32'h8000_0000);
    chk("pin_out", pin_out, gpio_out & 32'h7FFF_FFFF);
    chk("oe_small", oe_s, 32'hFFFF_FFDA);
    chk("oe_medium", oe_m, 32'hFFFF_8F5A);
    for (int p = 0; p < 4; p++)
    begin
      apb(1'b0, {IDX_PORT0_ORIENT + 10'(p), 2'b00}, 32'h0);
      chk("orient_rd", rd, {24'h0, v[8*p+:8]});
    end
    // Outputs read back the device drive, inputs the board level
    chk("gpio_in", gpio_in, ((gpio_out & ~v) | (ext_val & v)) & 32'h7FFF_FFFF);
  endtask : t_dir

  task automatic t_lf();
    logic [2:0] c;
    apb(1'b1, {IDX_PORT0_ORIENT, 2'b00}, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      c = (i == 0) ? 3'h0 : ((i == 1) ? 3'h3 : 3'h4);
      apb(1'b1, {IDX_LF_SELECT, 2'b00}, {29'h0, c});
      ext_val[0][1] <= 1'b1;
      tick(3);
      chk("lf_sel", {lf_xtal_en, lf_lowamp_sel, lf_digital_sel}, {c == 3'h0, c == 3'h3, c == 3'h4});
      chk("lf_oe_n", pin_oe_n[0], (c == 3'h0) ? 8'h03 : ((c == 3'h3) ? 8'h02 : 8'h00));
      chk("lf_clk_hi", lf_lowamp_clk, c == 3'h3);
      ext_val[0][1] <= 1'b0;
      tick(3);
      chk("lf_clk_lo", lf_lowamp_clk, 1'b0);
    end
    apb(1'b1, {IDX_LF_SELECT, 2'b00}, 32'h1);
  endtask : t_lf

  task automatic t_flash();
    flash_miso <= ~gpio_out[1][6];
    ext_val[1][2] <= 1'b1;
    tick(3);
    chk("fl_off", {flash_sck, flash_mosi, flash_csn_n}, 3'b001);
    chk("p16_off", pin_out[1][6], gpio_out[1][6]);
    program_mode_pin <= 1'b1;
    ext_val[2][0] <= 1'b0;
    tick(3);
    chk("fl_sck_on", flash_sck, 1'b1);
    chk("p16_on", {pin_oe_n[1][6], pin_out[1][6]}, {1'b0, ~gpio_out[1][6]});
    chk("fl_on", {flash_mosi, flash_csn_n}, {gpio_out[1][5], 1'b0});
    program_mode_pin <= 1'b0;
    tick(3);
    chk("fl_sck_off", flash_sck, 1'b0);
  endtask : t_flash

  task automatic t_err();
    apb(1'b0, 12'h004, 32'h0);
    chk("unmapped_err", er, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    apb(1'b1, {IDX_PORT0_ORIENT, 2'b01}, 32'hFF);
    chk("misaligned", er, 1'b1);
    apb(1'b0, {IDX_PORT0_ORIENT, 2'b00}, 32'h0);
    chk("orient_kept_err", er, 1'b0);
    chk("orient_kept", rd, 32'h0);
  endtask : t_err

  task automatic t_option();
    apb(1'b1, {IDX_PORT0_OPTION, 2'b00}, 32'hA5);
    tick(2);
    chk("option", port_option[0], 8'hA5);
    chk("oe_n_kept", pin_oe_n[0], 8'h00);
  endtask : t_option

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done();
  end

  initial
  begin
    error_cnt = 0;
    checked = 0;
    sys_rst = 1'b1;
    {psel, penable, pwrite, program_mode_pin, flash_miso} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    gpio_out = 32'h3CA5_696B;
    ext_val = 32'hA5C3_96E1;
    tick(20);
    sys_rst <= 1'b0;
    tick(2);
    t_reset();
    t_dir();
    t_lf();
    t_flash();
    t_err();
    t_option();
    sys_rst <= 1'b1;
    tick(3);
    sys_rst <= 1'b0;
    tick(2);
    t_reset();
    test_done();
  end
endmodule : test_port_pin_orientation_crossbar
